// File: logic/spoc_defs.vh
`ifndef SPOC_DEFS_VH
`define SPOC_DEFS_VH

// Register byte offsets on the APB bus
`define SPOC_OFF_CTRL       8'h00
`define SPOC_OFF_LIMIT      8'h04
`define SPOC_OFF_CURRENT    8'h08
`define SPOC_OFF_STATUS     8'h0C

// Control register bit positions (write one to act)
`define SPOC_CTRL_CLEAR     0
`define SPOC_CTRL_CLR_INT   1

// Status register bit positions
`define SPOC_STAT_ACTIVE    0
`define SPOC_STAT_INT       1
`define SPOC_STAT_MCLR      2
`define SPOC_STAT_WAIT      3

// Reset values
`define SPOC_RST_ADDR       32'h0000_0000
`define SPOC_RST_PARCEL     16'h0000
`define SPOC_RST_PARITY     4'hF

// Parcel bookkeeping
`define SPOC_PARCELS        4
`define SPOC_LAST_PARCEL    2'h3

`endif

// File: logic/spoc_sync.v
`timescale 1ns/1ps
// Two-flop synchroniser for levels arriving from outside the pclk domain
module spoc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             pclk,
  input  wire             presetn,
  // Asynchronous input and synchronised output
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;   // First stage, read only by the second stage
  reg [WIDTH-1:0] sync_q;   // Second stage, safe for logic

  // Two flip-flops in series
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// File: logic/spoc_parity.v
`timescale 1ns/1ps
// Odd parity per nibble of a parcel
module spoc_parity #(
  parameter NIBBLES = 4
) (
  // Parcel in, one parity bit per nibble out
  input  wire [4*NIBBLES-1:0] parcel,
  output wire [NIBBLES-1:0]   parity
);

  genvar g;
  // Each bit makes its nibble plus itself hold an odd count of ones
  generate
    for (g = 0; g < NIBBLES; g = g + 1) begin : g_nib
      assign parity[g] = ~^parcel[4*g+3:4*g];
    end
  endgenerate

endmodule

// File: logic/spoc_channel.v
`timescale 1ns/1ps
`include "spoc_defs.vh"
module spoc_channel #(
  parameter ADDR_W = 22
) (
  // APB clock and reset
  input  wire              pclk,
  input  wire              presetn,
  // APB slave
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [7:0]        paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // Memory read port, same clock
  output reg               mem_req,
  output reg  [ADDR_W-1:0] mem_addr,
  input  wire              mem_ack,
  input  wire [63:0]       mem_rdata,
  // Link pins
  input  wire              link_clk,
  input  wire              resume_in,
  output reg               chan_clk_out,
  output reg  [15:0]       chan_data,
  output reg  [3:0]        chan_parity,
  output reg               chan_ready,
  output reg               chan_disconnect,
  output wire              chan_master_clear,
  // System level signals
  input  wire              io_clear,
  output wire              chan_int
);

  // One-hot sequencer states
  localparam ST_IDLE  = 4'b0001;
  localparam ST_FETCH = 4'b0010;
  localparam ST_SEND  = 4'b0100;
  localparam ST_WAIT  = 4'b1000;
  // Address reset value, cut to the address width
  localparam [31:0] RST_ADDR = `SPOC_RST_ADDR;

  // Control state
  reg [3:0]        state_q;        // Sequencer state
  reg [3:0]        state_d;
  reg [ADDR_W-1:0] limit_q;        // Limit address
  reg [ADDR_W-1:0] current_q;      // Current address
  reg              active_q;       // Channel active
  reg              int_q;          // Channel interrupt flag
  reg              mclr_q;         // Programmed master clear level
  reg              first_q;        // First parcel of block still pending
  reg [1:0]        idx_q;          // Next parcel to send
  reg [63:0]       word_q;         // Word being sent
  reg              resume_pend_q;  // Resume seen, not yet used
  reg              lclk_prev_q;    // Link clock delayed for edge find
  reg              resume_prev_q;  // Resume delayed for edge find

  // Synchronised link inputs
  wire [1:0]  sync_out;
  wire        lclk_s   = sync_out[0];
  wire        resume_s = sync_out[1];

  // Edges of the synchronised link signals
  wire        link_edge   = lclk_s & ~lclk_prev_q;
  wire        resume_rise = resume_s & ~resume_prev_q;

  // APB decode
  wire        apb_wr  = psel & penable & pwrite;
  wire        rd_setup = psel & ~penable & ~pwrite;  // Setup cycle of a read
  wire        hit_ctrl    = (paddr == `SPOC_OFF_CTRL);
  wire        hit_limit   = (paddr == `SPOC_OFF_LIMIT);
  wire        hit_current = (paddr == `SPOC_OFF_CURRENT);
  wire        hit_status  = (paddr == `SPOC_OFF_STATUS);
  wire        hit_any = hit_ctrl | hit_limit | hit_current | hit_status;

  // Instruction-like events decoded from writes
  wire        wr_clear   = apb_wr & hit_ctrl & pwdata[`SPOC_CTRL_CLEAR];
  wire        wr_clr_int = apb_wr & hit_ctrl & pwdata[`SPOC_CTRL_CLR_INT];
  wire        wr_limit   = apb_wr & hit_limit;
  wire        wr_current = apb_wr & hit_current;
  wire [ADDR_W-1:0] wdata_addr = pwdata[ADDR_W-1:0];

  // Activation when the loaded current differs from the limit
  wire        start_xfer = wr_current & ~active_q & (wdata_addr != limit_q);
  // Equal load requests the programmed master clear
  wire        mclr_set   = wr_current & ~active_q & (wdata_addr == limit_q);

  // Parcel selection, most significant first
  reg  [15:0] parcel_sel;
  wire [3:0]  parcel_par;
  wire        word_last  = (current_q == limit_q);
  wire        emit       = (state_q == ST_SEND) & link_edge;
  wire        word_done  = emit & (idx_q == `SPOC_LAST_PARCEL) & ~first_q;
  wire        block_end  = word_done & word_last;

  // Link clock and resume synchroniser
  spoc_sync #(
    .WIDTH (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({resume_in, link_clk}),
    .sync_out (sync_out)
  );

  // Nibble parity of the selected parcel
  spoc_parity #(
    .NIBBLES (4)
  ) u_parity (
    .parcel (parcel_sel),
    .parity (parcel_par)
  );

  // APB always answers at once; unmapped addresses flag an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Master clear is a level, from software or from a system clear
  assign chan_master_clear = mclr_q | io_clear;
  // Interrupt level straight from its flag
  assign chan_int = int_q;

  // Pick the parcel by index
  always @* begin
    case (idx_q)
      2'd0:    parcel_sel = word_q[63:48];
      2'd1:    parcel_sel = word_q[47:32];
      2'd2:    parcel_sel = word_q[31:16];
      default: parcel_sel = word_q[15:0];
    endcase
  end

  // Sequencer next state
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        // Start on a differing address load
        if (start_xfer) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // Word arrives from memory
        if (mem_ack) begin
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (emit) begin
          if (first_q) begin
            // Lone first parcel, then wait for resume
            state_d = ST_WAIT;
          end else if (idx_q == `SPOC_LAST_PARCEL) begin
            // Word finished: end block or fetch the next
            state_d = word_last ? ST_IDLE : ST_FETCH;
          end
        end
      end
      ST_WAIT: begin
        // Resume releases the rest of the block
        if (resume_pend_q) begin
          state_d = ST_SEND;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Channel clear returns the sequencer to idle; the master clear level is kept
    if (wr_clear) begin
      state_d = ST_IDLE;
    end
  end

  // Sequencer state register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Edge detector registers and forwarded clock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lclk_prev_q   <= 1'b0;
      resume_prev_q <= 1'b0;
      chan_clk_out  <= 1'b0;
    end else begin
      lclk_prev_q   <= lclk_s;
      resume_prev_q <= resume_s;
      // Interface clock trails the strobes by one cycle so the far end sees settled lines
      chan_clk_out  <= lclk_prev_q;
    end
  end

  // Address registers and activity flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_q   <= RST_ADDR[ADDR_W-1:0];
      current_q <= RST_ADDR[ADDR_W-1:0];
      active_q  <= 1'b0;
    end else begin
      // Limit load
      if (wr_limit) begin
        limit_q <= wdata_addr;
      end
      // Current load, or advance after each memory read
      if (wr_current) begin
        current_q <= wdata_addr;
      end else if ((state_q == ST_FETCH) && mem_ack) begin
        current_q <= current_q + 1'b1;
      end
      // Activity follows start, block end and channel clear
      if (wr_clear || block_end) begin
        active_q <= 1'b0;
      end else if (start_xfer) begin
        active_q <= 1'b1;
      end
    end
  end

  // Interrupt flag: a block end in the clearing cycle still sets it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_q <= 1'b0;
    end else if (block_end) begin
      int_q <= 1'b1;
    end else if (wr_clear || wr_clr_int) begin
      int_q <= 1'b0;
    end
  end

  // Programmed master clear level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclr_q <= 1'b0;
    end else if (mclr_set) begin
      mclr_q <= 1'b1;
    end else if (wr_limit) begin
      mclr_q <= 1'b0;
    end
  end

  // Resume catcher; a new resume wins over consumption
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resume_pend_q <= 1'b0;
    end else if (resume_rise) begin
      resume_pend_q <= 1'b1;
    end else if (start_xfer || (state_q == ST_WAIT)) begin
      resume_pend_q <= 1'b0;
    end
  end

  // Memory read request and word capture
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_req  <= 1'b0;
      mem_addr <= {ADDR_W{1'b0}};
      word_q   <= {64{1'b0}};
    end else begin
      // Request stands until acknowledged
      mem_req  <= (state_d == ST_FETCH) & ~((state_q == ST_FETCH) & mem_ack);
      if (state_d == ST_FETCH) begin
        mem_addr <= (state_q == ST_FETCH) ? current_q : wdata_addr;
        if (state_q != ST_IDLE) begin
          mem_addr <= current_q;
        end
      end
      if ((state_q == ST_FETCH) && mem_ack) begin
        word_q <= mem_rdata;
      end
    end
  end

  // Parcel index and first-parcel marker
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q   <= 2'd0;
      first_q <= 1'b0;
    end else begin
      if (start_xfer) begin
        first_q <= 1'b1;
      end else if (emit) begin
        first_q <= 1'b0;
      end
      if ((state_q == ST_FETCH) && mem_ack) begin
        idx_q <= 2'd0;
      end else if (emit) begin
        idx_q <= idx_q + 2'd1;
      end
    end
  end

  // Link outputs change only on a link clock rising edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chan_data       <= `SPOC_RST_PARCEL;
      chan_parity     <= `SPOC_RST_PARITY;
      chan_ready      <= 1'b0;
      chan_disconnect <= 1'b0;
    end else if (link_edge) begin
      // Strobes last one link clock cycle
      chan_ready      <= emit;
      chan_disconnect <= emit & (idx_q == 2'd0) & word_last;
      if (emit) begin
        // All sixteen bits and parity move together and then hold
        chan_data   <= parcel_sel;
        chan_parity <= parcel_par;
      end
    end
  end

  // Read data taken in the setup cycle, so it stands from a flip-flop in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      // Zero outside the access cycle of a read
      prdata <= 32'h0000_0000;
      if (rd_setup) begin
        if (hit_limit) begin
          prdata[ADDR_W-1:0] <= limit_q;
        end else if (hit_current) begin
          prdata[ADDR_W-1:0] <= current_q;
        end else if (hit_status) begin
          prdata[`SPOC_STAT_ACTIVE] <= active_q;
          prdata[`SPOC_STAT_INT]    <= int_q;
          prdata[`SPOC_STAT_MCLR]   <= chan_master_clear;
          prdata[`SPOC_STAT_WAIT]   <= (state_q == ST_WAIT);
        end
      end
    end
  end

endmodule

// File: dv/spoc_channel_checker.sv
`timescale 1ns/1ps
`include "spoc_defs.vh"
// Port-level checks of the output channel
module spoc_channel_checker #(
  parameter ADDR_W = 22
) (
  // Clock and reset
  input wire              pclk,
  input wire              presetn,
  // Bus and memory side
  input wire              psel,
  input wire              penable,
  input wire [7:0]        paddr,
  input wire              pslverr,
  input wire              mem_req,
  input wire [ADDR_W-1:0] mem_addr,
  input wire              mem_ack,
  // Link side
  input wire [15:0]       chan_data,
  input wire [3:0]        chan_parity,
  input wire              chan_ready,
  input wire              chan_disconnect,
  input wire              chan_master_clear,
  input wire              io_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_parity_odd: assert property (
    (chan_parity ^ {^chan_data[15:12], ^chan_data[11:8], ^chan_data[7:4],
    ^chan_data[3:0]}) == 4'hF) else $error("parity not odd");
  a_data_hold: assert property (
    $changed(chan_data) |-> chan_ready) else $error("data moved without ready");
  a_parity_hold: assert property (
    $changed(chan_parity) |-> $changed(chan_data)) else $error("parity moved alone");
  a_ready_width: assert property (
    $rose(chan_ready) |-> chan_ready [*8]) else $error("ready too short");
  a_disc_ready: assert property (
    chan_disconnect |-> chan_ready) else $error("disconnect without ready");
  a_mclr_io: assert property (
    io_clear |-> chan_master_clear) else $error("io clear not forwarded");
  a_mem_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr)) else $error("request moved");
  a_mem_drop: assert property (
    mem_req && mem_ack |=> !mem_req) else $error("request kept after ack");
  a_slverr_map: assert property (
    psel && penable |-> pslverr == !(paddr == `SPOC_OFF_CTRL || paddr == `SPOC_OFF_LIMIT ||
    paddr == `SPOC_OFF_CURRENT || paddr == `SPOC_OFF_STATUS)) else $error("bad slave error");
endmodule

// File: dv/spoc_far_dev.sv
`timescale 1ns/1ps
// Far disk controller: one resume, some link clocks after the first ready
module spoc_far_dev #(
  parameter [3:0] DELAY = 4'h5
) (
  // Supplied clock and reset
  input wire clk,
  input wire presetn,
  // Link pins; master clear is ignored
  input wire chan_ready,
  input wire chan_master_clear,
  output reg resume,
  // Bench arms one resume per block
  input wire arm
);
  reg [3:0] wait_q;  // Link clocks left before resume
  reg       fired_q; // Resume already given for this block
  // Answer only the first ready after arming
  always @(posedge clk or negedge presetn) begin
    if (!presetn) begin
      resume <= 1'b0;
      wait_q <= 4'h0;
      fired_q <= 1'b0;
    end else begin
      resume <= (wait_q == 4'h1);
      if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
      if (!arm) fired_q <= 1'b0;
      else if (chan_ready && !fired_q) begin
        fired_q <= 1'b1;
        wait_q <= DELAY;
      end
    end
  end
endmodule

// File: dv/tb_sync_parcel_output_channel.sv
`timescale 1ns/1ps
`include "spoc_defs.vh"
// Compare and count
`define CHK(nm, e, g) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
  n_mismatch = n_mismatch + 1; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_sync_parcel_output_channel;
  reg         pclk = 0, link_clk = 0, presetn = 0, io_clear = 0, arm = 0;
  reg         psel = 0, penable = 0, pwrite = 0, mem_ack = 0;
  reg  [7:0]  paddr = 0;
  reg  [31:0] pwdata = 0, d;
  reg  [63:0] mem_rdata = 0;
  wire [31:0] prdata;
  wire [21:0] mem_addr;
  wire [15:0] chan_data;
  wire [3:0]  chan_parity;
  wire        pready, pslverr, mem_req, resume_in, chan_clk_out, chan_ready;
  wire        chan_disconnect, chan_master_clear, chan_int;
  reg         e;
  reg  [2:0]  ph = 0;    // Cycle within one parcel's ready
  reg  [20:0] got [$];   // Captured {disconnect, parity, data}
  integer     n_mismatch = 0, tests_run = 0, k;
  // Clocks of unrelated phase
  always #20 pclk = ~pclk;
  initial begin #7; forever #160 link_clk = ~link_clk; end
  spoc_channel dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .link_clk(link_clk), .resume_in(resume_in),
    .chan_clk_out(chan_clk_out), .chan_data(chan_data), .chan_parity(chan_parity),
    .chan_ready(chan_ready), .chan_disconnect(chan_disconnect),
    .chan_master_clear(chan_master_clear), .io_clear(io_clear), .chan_int(chan_int));
  spoc_far_dev far (.clk(chan_clk_out), .presetn(presetn), .chan_ready(chan_ready),
    .chan_master_clear(chan_master_clear), .resume(resume_in), .arm(arm));
  // Memory word made from its address
  function [63:0] word(input [21:0] a);
    word = {4'hA, a[11:0], 4'h5, a[11:0], 4'hC, a[11:0], 4'h3, a[11:0]};
  endfunction
  // Memory answers one cycle after a request
  always @(posedge pclk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= word(mem_addr);
  end
  // One parcel per eight cycles of ready
  always @(posedge pclk) begin
    ph <= chan_ready ? ph + 3'h1 : 3'h0;
    if (chan_ready && ph == 3'h0) got.push_back({chan_disconnect, chan_parity, chan_data});
  end
  task apb(input w, input [7:0] a, input [31:0] wd);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // Send a block and compare every parcel
  task run_block(input [21:0] b, input integer n);
    reg [15:0] p;
    integer    i;
    arm <= 1;
    apb(1, `SPOC_OFF_LIMIT, b + n);
    apb(1, `SPOC_OFF_CURRENT, b);
    for (k = 0; k < 400 && got.size() == 0; k++) @(posedge pclk);
    repeat (24) @(posedge pclk);
    `CHK("parcels before resume", 1, got.size())
    apb(0, `SPOC_OFF_STATUS, 0);
    `CHK("waiting for resume", 4'b1001, d[3:0])
    for (k = 0; k < 60000 && chan_int !== 1'b1; k++) @(posedge pclk);
    arm <= 0;
    @(negedge pclk);
    `CHK("parcels", n * 4, got.size())
    for (i = 0; i < n * 4; i++) begin
      p = 16'(word(b + 22'(i / 4)) >> (16 * (3 - i % 4)));
      `CHK("data", p, got[i][15:0])
      `CHK("parity", ~{^p[15:12], ^p[11:8], ^p[7:4], ^p[3:0]}, got[i][19:16])
      `CHK("disconnect", (i == 4 * n - 4), got[i][20])
    end
    got.delete();
    apb(0, `SPOC_OFF_STATUS, 0);
    `CHK("status", 2'b10, d[1:0])
    apb(0, `SPOC_OFF_CURRENT, 0);
    `CHK("current", b + n, d[21:0])
    apb(1, `SPOC_OFF_CTRL, 32'h0000_0002);
    @(negedge pclk);
    `CHK("int cleared", 1'b0, chan_int)
  endtask
  task tally_and_finish;
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    `CHK("reset parity", `SPOC_RST_PARITY, chan_parity)
    apb(0, `SPOC_OFF_STATUS, 0);
    `CHK("reset status", 32'h0000_0000, d)
    apb(0, 8'h10, 0);
    `CHK("unmapped err", 1'b1, e)
    run_block(22'h00_0100, 1);
    run_block(22'h00_2000, 512);
    apb(1, `SPOC_OFF_LIMIT, 32'h0000_0055);
    apb(1, `SPOC_OFF_CURRENT, 32'h0000_0055);
    repeat (4) @(negedge pclk);
    `CHK("clear raised", 1'b1, chan_master_clear)
    `CHK("no fetch", 1'b0, mem_req)
    apb(1, `SPOC_OFF_CTRL, 32'h0000_0001);
    repeat (40) @(negedge pclk);
    `CHK("clear held", 1'b1, chan_master_clear)
    `CHK("no parcels", 0, got.size())
    apb(1, `SPOC_OFF_LIMIT, 32'h0000_0055);
    @(negedge pclk);
    `CHK("clear dropped", 1'b0, chan_master_clear)
    repeat (160) @(posedge pclk);
    apb(0, `SPOC_OFF_STATUS, 0);
    apb(0, `SPOC_OFF_STATUS, 0);
    `CHK("status after clear", 32'h0000_0000, d)
    @(posedge pclk);
    io_clear <= 1;
    @(negedge pclk);
    `CHK("io clear", 1'b1, chan_master_clear)
    tally_and_finish;
  end
  // Cut a hang short
  initial begin
    #3_000_000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule
bind spoc_channel spoc_channel_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .chan_data(chan_data),
  .chan_parity(chan_parity), .chan_ready(chan_ready), .chan_disconnect(chan_disconnect),
  .chan_master_clear(chan_master_clear), .io_clear(io_clear));
